// File: rtl/fcd_pkg.sv
package fcd_pkg;
	localparam int SLOTS = 4;
	localparam int DATA_W = 16;
	localparam int PERIOD_W = 13;
	localparam int ADDR_W = 8;

	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_SLOT0 = 8'h04;
	localparam logic [7:0] OFF_SLOT3 = 8'h10;
	localparam logic [7:0] OFF_PERIOD = 8'h14;

	localparam int BIT_IMM = 0;
	localparam int BIT_AWS = 1;
	localparam int BIT_FORCE = 2;
	localparam int BIT_ARS = 3;
	localparam int BIT_HOLD = 4;
	localparam int BIT_ALY = 5;
	localparam logic [15:0] CFG_MASK = 16'h003F;

	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [12:0] PERIOD_RESET = 13'h00FF;
	localparam logic [15:0] SAMPLE_RESET = 16'h0000;

	// Quarter-bit is 12/13 us; slightly fast rather than slow
	localparam int QBIT_PS = 923077;
	localparam int CLK_PS = 10000;
	localparam int QBIT_CYCLES = QBIT_PS / CLK_PS;
endpackage

// File: rtl/fcd_win_if.sv
interface fcd_win_if #(
	parameter int PW = 13
);
	logic reload;
	logic [PW-1:0] period;
	logic active;
	logic [PW-1:0] count;
	modport ctrl(output reload, output period, input active, input count);
	modport timer(input reload, input period, output active, output count);
endinterface

// File: rtl/fcd_window.sv
module fcd_window #(
	parameter int PW = fcd_pkg::PERIOD_W,
	parameter int QDIV = fcd_pkg::QBIT_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	fcd_win_if.timer win
);
	localparam int DW = $clog2(QDIV);
	localparam logic [DW-1:0] DIV_LAST = DW'(QDIV - 1);

	logic [DW-1:0] div;
	logic [DW-1:0] next_div;
	logic [PW-1:0] count;
	logic [PW-1:0] next_count;
	logic active;
	logic next_active;
	logic tick;

	assign tick = (div == DIV_LAST);
	assign win.active = active;
	assign win.count = count;

	always_comb begin
		next_div = tick ? '0 : div + 1'b1;
		next_count = count;
		next_active = active;
		if (win.reload) begin
			// Restart divider so every window is a whole number of ticks
			next_div = '0;
			next_count = win.period;
			next_active = 1'b1;
		end else if (tick && active) begin
			if (count == '0) begin
				next_active = 1'b0;
			end else begin
				next_count = count - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			div <= '0;
			count <= '0;
			active <= 1'b0;
		end else begin
			div <= next_div;
			count <= next_count;
			active <= next_active;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	win_reload_a: assert property (win.reload |=>
		active && count == $past(win.period))
		else $error("window did not load the period");
	win_expire_a: assert property (active && count == '0 && tick &&
		!win.reload |=> !active)
		else $error("window did not close at zero");
	win_step_a: assert property (active && count != '0 && tick &&
		!win.reload |=> active && count == $past(count) - 1'b1)
		else $error("window count did not step");
	win_expire_c: cover property (active ##1 !active);
endmodule

// File: rtl/fcd_sequencer.sv
// Contract
// - Event-valid copies all write buffers to active.
// - Event n loads active buffer n to output.
// - Each event powers converter for programmed window.
// - Immediate mode drives slot0 write buffer directly.
// - Immediate mode also forces converter power on.
// - Leaving immediate starts window; events extend it.
// - Reference clock request powers converter, keeps value.
// - Read select picks write or active buffer.
// - Write select picks write or active buffer.
// - Force flag keeps converter powered continuously.
// - Hold keeps converter driving after window ends.
// - Always-on overrides global power-down control.
// - Period is 13 bits, resets 255, forced-ignored.
// - Slots unreset; output register starts at zero.
module fcd_sequencer #(
	parameter int SLOTS = fcd_pkg::SLOTS,
	parameter int DW = fcd_pkg::DATA_W,
	parameter int PW = fcd_pkg::PERIOD_W,
	parameter int QDIV = fcd_pkg::QBIT_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fcd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_valid_strobe,
	input wire logic [SLOTS-1:0] tuning_event_pulse,
	input wire logic ref_clock_request_in,
	input wire logic global_power_down_ctrl,
	output logic [DW-1:0] tuning_sample,
	output logic converter_power_gate
);
	logic [15:0] cfg;
	logic [15:0] next_cfg;
	logic [PW-1:0] period;
	logic [PW-1:0] next_period;
	logic [DW-1:0] wbuf [SLOTS];
	logic [DW-1:0] next_wbuf [SLOTS];
	logic [DW-1:0] abuf [SLOTS];
	logic [DW-1:0] next_abuf [SLOTS];
	logic [DW-1:0] next_sample;
	logic [31:0] next_prdata;
	logic next_gate;
	logic imm_prev;
	logic hold_keep;
	logic next_hold_keep;
	logic imm_mode;
	logic force_pwr;
	logic wr_access;
	logic rd_setup;
	logic [2:0] wslot;
	logic pwr_req;

	fcd_win_if #(.PW(PW)) win();

	fcd_window #(.PW(PW), .QDIV(QDIV)) u_window (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.win(win)
	);

	// Returns {hit, index} for the four data slot offsets
	function automatic logic [2:0] fcd_slot(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - fcd_pkg::OFF_SLOT0;
		if (a >= fcd_pkg::OFF_SLOT0 && a <= fcd_pkg::OFF_SLOT3 &&
			a[1:0] == 2'b00) begin
			return {1'b1, rel[3:2]};
		end
		return 3'b000;
	endfunction

	assign imm_mode = cfg[fcd_pkg::BIT_IMM];
	// Immediate implies forced power-up
	assign force_pwr = cfg[fcd_pkg::BIT_FORCE] | imm_mode;
	assign wr_access = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wslot = fcd_slot(paddr);
	assign pready = 1'b1;
	assign win.period = period;
	// Events extend the window; leaving immediate opens one
	assign win.reload = (|tuning_event_pulse) | (imm_prev & ~imm_mode);
	// Hold and ref request only sustain, they never alter the value
	// Reload counts as a request so the gate never dips while the window
	// restarts after immediate mode ends
	assign pwr_req = force_pwr | win.active | ref_clock_request_in |
		hold_keep | win.reload;

	always_comb begin
		pslverr = 1'b0;
		if (psel && penable && paddr != fcd_pkg::OFF_CONFIG &&
			paddr != fcd_pkg::OFF_PERIOD && !wslot[2]) begin
			pslverr = 1'b1;
		end
	end

	always_comb begin
		next_cfg = cfg;
		next_period = period;
		next_wbuf = wbuf;
		next_abuf = abuf;
		if (wr_access) begin
			if (paddr == fcd_pkg::OFF_CONFIG) begin
				next_cfg = pwdata[15:0] & fcd_pkg::CFG_MASK;
			end else if (paddr == fcd_pkg::OFF_PERIOD) begin
				next_period = pwdata[PW-1:0];
			end else if (wslot[2]) begin
				if (cfg[fcd_pkg::BIT_AWS]) begin
					next_abuf[wslot[1:0]] = pwdata[DW-1:0];
				end else begin
					next_wbuf[wslot[1:0]] = pwdata[DW-1:0];
				end
			end
		end
		if (event_valid_strobe) begin
			// Latch after the bus write so it wins the same cycle
			next_abuf = wbuf;
		end
	end

	always_comb begin
		next_sample = tuning_sample;
		if (imm_mode) begin
			next_sample = wbuf[0];
		end else begin
			// Lowest index wins if the timer ever overlaps events
			for (int i = SLOTS - 1; i >= 0; i--) begin
				if (tuning_event_pulse[i]) begin
					next_sample = abuf[i];
				end
			end
		end
	end

	always_comb begin
		next_hold_keep = cfg[fcd_pkg::BIT_HOLD] &
			(hold_keep | converter_power_gate);
		next_gate = pwr_req &
			(~global_power_down_ctrl | cfg[fcd_pkg::BIT_ALY]);
	end

	always_comb begin
		next_prdata = '0;
		if (rd_setup) begin
			if (paddr == fcd_pkg::OFF_CONFIG) begin
				next_prdata = {16'h0000, cfg};
			end else if (paddr == fcd_pkg::OFF_PERIOD) begin
				next_prdata = {{(32-PW){1'b0}}, period};
			end else if (wslot[2]) begin
				if (cfg[fcd_pkg::BIT_ARS]) begin
					next_prdata = {{(32-DW){1'b0}}, abuf[wslot[1:0]]};
				end else begin
					next_prdata = {{(32-DW){1'b0}}, wbuf[wslot[1:0]]};
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cfg <= fcd_pkg::CFG_RESET;
			period <= fcd_pkg::PERIOD_RESET;
			tuning_sample <= fcd_pkg::SAMPLE_RESET;
			prdata <= '0;
			converter_power_gate <= 1'b0;
			imm_prev <= 1'b0;
			hold_keep <= 1'b0;
		end else begin
			cfg <= next_cfg;
			period <= next_period;
			tuning_sample <= next_sample;
			prdata <= next_prdata;
			converter_power_gate <= next_gate;
			imm_prev <= imm_mode;
			hold_keep <= next_hold_keep;
		end
	end

	// Slot storage has no reset; software must load it first
	always_ff @(posedge core_clk) begin
		wbuf <= next_wbuf;
		abuf <= next_abuf;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	evt_copy_a: assert property (event_valid_strobe |=>
		abuf[0] == $past(wbuf[0]) && abuf[3] == $past(wbuf[3]))
		else $error("event valid did not copy write buffers");
	evt_out_a: assert property (!imm_mode && tuning_event_pulse == 4'h4
		|=> tuning_sample == $past(abuf[2]))
		else $error("event did not load its active buffer");
	imm_out_a: assert property (imm_mode |=>
		tuning_sample == $past(wbuf[0]))
		else $error("immediate mode output mismatch");
	force_pwr_a: assert property (force_pwr && !global_power_down_ctrl
		|=> converter_power_gate)
		else $error("forced mode did not power converter");
	event_pwr_a: assert property (tuning_event_pulse != '0 &&
		!global_power_down_ctrl ##1 !global_power_down_ctrl
		|=> converter_power_gate)
		else $error("event did not power converter");
	imm_leave_a: assert property ($fell(imm_mode) |-> win.reload)
		else $error("leaving immediate did not open window");
	ref_req_a: assert property (ref_clock_request_in &&
		!global_power_down_ctrl && tuning_event_pulse == '0 && !imm_mode
		|=> converter_power_gate && $stable(tuning_sample))
		else $error("ref request did not power with held value");
	rd_sel_a: assert property (rd_setup && paddr == 8'h08 &&
		cfg[fcd_pkg::BIT_ARS] |=> prdata[15:0] == $past(abuf[1]))
		else $error("active read returned wrong buffer");
	wr_sel_a: assert property (wr_access && paddr == 8'h0C &&
		cfg[fcd_pkg::BIT_AWS] && !event_valid_strobe
		|=> abuf[2] == $past(pwdata[15:0]))
		else $error("active write missed active buffer");
	hold_keep_a: assert property (cfg[fcd_pkg::BIT_HOLD] &&
		converter_power_gate && !global_power_down_ctrl ##1
		cfg[fcd_pkg::BIT_HOLD] && !global_power_down_ctrl
		|=> converter_power_gate)
		else $error("hold mode let converter power down");
	gpd_off_a: assert property (global_power_down_ctrl &&
		!cfg[fcd_pkg::BIT_ALY] |=> !converter_power_gate)
		else $error("global power down ignored");
	reset_val_a: assert property ($rose(reset_n) |->
		period == 13'h00FF && tuning_sample == 16'h0000 && cfg == 16'h0000)
		else $error("reset values wrong");
	latch_win_a: assert property (event_valid_strobe && wr_access &&
		paddr == 8'h04 && cfg[fcd_pkg::BIT_AWS] |=> abuf[0] == $past(wbuf[0]))
		else $error("bus write beat event valid latch");

	event_c: cover property (!imm_mode && tuning_event_pulse != '0);
	imm_c: cover property (imm_mode ##1 !imm_mode);
	evtval_c: cover property (event_valid_strobe ##[1:4] tuning_event_pulse[0]);
	hold_c: cover property (hold_keep && !win.active);
endmodule

// File: testbench/fcd_timer_model.sv
module fcd_timer_model (
	input wire logic core_clk,
	output logic event_valid_strobe,
	output logic [fcd_pkg::SLOTS-1:0] tuning_event_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	int frame_events;
	initial begin
		event_valid_strobe = 1'b0;
		tuning_event_pulse = '0;
		frame_events = 0;
	end
	task automatic new_frame();
		frame_events = 0;
	endtask
	task automatic latch();
		@(negedge core_clk) event_valid_strobe = 1'b1;
		@(negedge core_clk) event_valid_strobe = 1'b0;
	endtask
	// Budget per frame, extra requests are dropped
	task automatic fire(input int n);
		if (frame_events < 4) begin
			frame_events++;
			@(negedge core_clk) tuning_event_pulse = 4'(1 << n);
			@(negedge core_clk) tuning_event_pulse = '0;
		end
	endtask
endmodule

// File: testbench/freq_ctrl_dac_sequencer_test.sv
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module freq_ctrl_dac_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int QD = 2;
	logic core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, ref_req = 1'b0, gpd = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic pready, pslverr, re, evs, gate;
	logic [3:0] tep;
	logic [15:0] ts, a;
	logic [15:0] sv[4], nv[4];
	int seed = 40895, err_count = 0, total_checks = 0, cnt;
	always #5 core_clk = ~core_clk;
	fcd_timer_model m (.core_clk(core_clk), .event_valid_strobe(evs),
		.tuning_event_pulse(tep));
	fcd_sequencer #(.QDIV(QD)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.event_valid_strobe(evs), .tuning_event_pulse(tep),
		.ref_clock_request_in(ref_req), .global_power_down_ctrl(gpd),
		.tuning_sample(ts), .converter_power_gate(gate));
	function automatic int win_len(input int p);
		return (p + 1) * QD;
	endfunction
	function automatic logic [7:0] slot(input int n);
		return fcd_pkg::OFF_SLOT0 + 8'(4 * n);
	endfunction
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(negedge core_clk);
		psel = 1'b1;
		pwrite = w;
		paddr = ad;
		pwdata = d;
		@(negedge core_clk) penable = 1'b1;
		#1 rv = prdata;
		re = pslverr;
		@(negedge core_clk);
		psel = 1'b0;
		penable = 1'b0;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	// Window span is loose by a few cycles for the tick divider phase
	task automatic win_check(input int p);
		settle(2);
		`CHK(gate, 1'b1)
		for (cnt = 2; cnt < 400 && gate !== 1'b0; cnt++) @(negedge core_clk);
		if (cnt == 400) begin
			err_count++;
			complete_run();
		end
		`CHK(cnt >= win_len(p) - 2 && cnt <= win_len(p) + 4, 1'b1)
	endtask
	initial begin
		settle(16);
		reset_n = 1'b1;
		`CHK(ts, 16'h0000)
		`CHK(gate, 1'b0)
		bus(0, fcd_pkg::OFF_CONFIG, 0);
		`CHK(rv, 32'h0000_0000)
		bus(0, fcd_pkg::OFF_PERIOD, 0);
		`CHK(rv, 32'h0000_00FF)
		bus(1, fcd_pkg::OFF_PERIOD, 32'hFFFF_FFFF);
		bus(0, fcd_pkg::OFF_PERIOD, 0);
		`CHK(rv, 32'h0000_1FFF)
		bus(1, fcd_pkg::OFF_PERIOD, 32'h3);
		bus(0, 8'h18, 0);
		`CHK(re, 1'b1)
		`CHK(rv, 32'h0)
		$display("reset and map test done");
		for (int n = 0; n < 4; n++) begin
			sv[n] = 16'($random(seed));
			bus(1, slot(n), {16'h0, sv[n]});
		end
		m.latch();
		for (int n = 0; n < 4; n++) begin
			nv[n] = 16'($random(seed));
			bus(1, slot(n), {16'h0, nv[n]});
		end
		bus(1, fcd_pkg::OFF_CONFIG, 32'h8);
		for (int n = 0; n < 4; n++) begin
			bus(0, slot(n), 0);
			`CHK(rv[15:0], sv[n])
		end
		bus(1, fcd_pkg::OFF_CONFIG, 32'h0);
		for (int n = 0; n < 4; n++) begin
			bus(0, slot(n), 0);
			`CHK(rv[15:0], nv[n])
		end
		for (int n = 3; n >= 0; n--) begin
			m.fire(n);
			`CHK(ts, sv[n])
		end
		$display("buffer and event test done");
		settle(20);
		m.new_frame();
		a = 16'($random(seed));
		bus(1, fcd_pkg::OFF_CONFIG, 32'h2);
		bus(1, slot(2), {16'h0, a});
		m.fire(2);
		`CHK(ts, a)
		win_check(3);
		ref_req = 1'b1;
		settle(3);
		`CHK(gate, 1'b1)
		`CHK(ts, a)
		ref_req = 1'b0;
		bus(1, fcd_pkg::OFF_CONFIG, 32'h10);
		m.fire(1);
		settle(20);
		`CHK(gate, 1'b1)
		bus(1, fcd_pkg::OFF_CONFIG, 32'h4);
		settle(3);
		`CHK(gate, 1'b1)
		gpd = 1'b1;
		settle(3);
		`CHK(gate, 1'b0)
		bus(1, fcd_pkg::OFF_CONFIG, 32'h24);
		settle(3);
		`CHK(gate, 1'b1)
		gpd = 1'b0;
		bus(1, fcd_pkg::OFF_CONFIG, 32'h0);
		settle(3);
		`CHK(gate, 1'b0)
		$display("power mode test done");
		a = 16'($random(seed));
		bus(1, slot(0), {16'h0, a});
		bus(1, fcd_pkg::OFF_CONFIG, 32'h1);
		settle(2);
		`CHK(ts, a)
		`CHK(gate, 1'b1)
		a = ~a;
		bus(1, slot(0), {16'h0, a});
		settle(2);
		`CHK(ts, a)
		m.fire(3);
		`CHK(ts, a)
		bus(1, fcd_pkg::OFF_CONFIG, 32'h0);
		win_check(3);
		$display("immediate test done");
		complete_run();
	end
endmodule
